// ---- htr_generator.sv ----
// Purpose: hybrid physical random generator with compression and deterministic stage
// Assumes: raw bits arrive synchronous to sys_clk, qualified by raw_valid
// Notes: any failure or defect blocks output until reset
//
// Overview of operation
// - Start-up total-failure check; failure means no output
// - Drop words touched by post-failure raw bits
// - Online statistical test at start-up and always
// - No output before test and seeding; block on defect
// - Every raw bit enters the online test
// - One output bit per compressed input bit
// - Deterministic stage, nonlinear transition and output functions
// - Words of 8 or 16 bits by select
// - Deterministic stage fed only by compressed source
// - Compression ratio steered by entropy estimator
// - Ratio raised when bias threatens byte entropy
// - Deterministic state is 351 bits
`timescale 1ns/1ps
`default_nettype none

module htr_generator
  import htr_pkg::*;
#(
  parameter int RUN_LIMIT = HTR_RUN_LIMIT,
  parameter int STARTUP_BITS = HTR_STARTUP_BITS
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic raw_bit,
  input wire logic raw_valid,
  input wire logic word16_sel,
  output logic [15:0] rnd_word,
  output logic rnd_valid,
  output htr_status_t status
);

  ////////////////////////////////////////////////////////////////////////////
  // Total-failure and online tests

  logic last_bit_q, last_bit_d;
  logic [5:0] run_q, run_d;
  logic [9:0] up_cnt_q, up_cnt_d;
  logic [8:0] win_q, win_d;
  logic [8:0] ones_q, ones_d;
  logic tfail_q, tfail_d;
  logic defect_q, defect_d;
  logic win_ok_q, win_ok_d;
  logic [2:0] ratio_q, ratio_d;
  logic [8:0] ones_now;
  logic [8:0] bias;
  logic win_end;

  always_comb
  begin
    last_bit_d = last_bit_q;
    run_d = run_q;
    up_cnt_d = up_cnt_q;
    win_d = win_q;
    ones_d = ones_q;
    tfail_d = tfail_q;
    defect_d = defect_q;
    win_ok_d = win_ok_q;
    ratio_d = ratio_q;
    ones_now = ones_q + {8'h00, raw_bit};
    bias = (ones_now > HTR_ONES_MID) ? ones_now - HTR_ONES_MID : HTR_ONES_MID - ones_now;
    win_end = raw_valid && (win_q == HTR_WIN_LAST);
    if (raw_valid)
    begin
      last_bit_d = raw_bit;
      if (up_cnt_q != 10'(STARTUP_BITS))
      begin
        up_cnt_d = up_cnt_q + 10'h001;
      end
      // Stuck source shows as a long run of one value
      if (raw_bit == last_bit_q)
      begin
        if (run_q != 6'(RUN_LIMIT))
        begin
          run_d = run_q + 6'h01;
        end
        if (run_q + 6'h01 >= 6'(RUN_LIMIT))
        begin
          tfail_d = 1'b1;
        end
      end
      else
      begin
        run_d = 6'h01;
      end
      // Every raw bit counted, no sampling gaps
      win_d = win_q + 9'h001;
      ones_d = ones_now;
      if (win_end)
      begin
        win_d = '0;
        ones_d = '0;
        if (ones_now < HTR_ONES_LO || ones_now > HTR_ONES_HI)
        begin
          defect_d = 1'b1;
        end
        else
        begin
          win_ok_d = 1'b1;
        end
        // Estimator: heavier bias, stronger compression
        if (bias > HTR_BIAS_UP && ratio_q != HTR_RATIO_MAX)
        begin
          ratio_d = ratio_q + 3'h1;
        end
        else if (bias < HTR_BIAS_DN && ratio_q != HTR_RATIO_MIN)
        begin
          ratio_d = ratio_q - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      last_bit_q <= 1'b0;
      run_q <= '0;
      up_cnt_q <= '0;
      win_q <= '0;
      ones_q <= '0;
      tfail_q <= 1'b0;
      defect_q <= 1'b0;
      win_ok_q <= 1'b0;
      ratio_q <= HTR_RATIO_MAX;
    end
    else
    begin
      last_bit_q <= last_bit_d;
      run_q <= run_d;
      up_cnt_q <= up_cnt_d;
      win_q <= win_d;
      ones_q <= ones_d;
      tfail_q <= tfail_d;
      defect_q <= defect_d;
      win_ok_q <= win_ok_d;
      ratio_q <= ratio_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compression and deterministic stage

  logic [2:0] cmp_cnt_q, cmp_cnt_d;
  logic cmp_acc_q, cmp_acc_d;
  logic cmp_valid;
  logic cmp_bit;
  logic [HTR_STATE_W-1:0] drg_q, drg_d;
  logic [9:0] seed_q, seed_d;
  logic fb;
  logic out_bit;

  always_comb
  begin
    cmp_cnt_d = cmp_cnt_q;
    cmp_acc_d = cmp_acc_q;
    cmp_valid = 1'b0;
    cmp_bit = cmp_acc_q ^ raw_bit;
    drg_d = drg_q;
    seed_d = seed_q;
    // Output depends on state only, never on input directly
    out_bit = drg_q[HTR_O_A] ^ drg_q[HTR_O_B] ^ (drg_q[HTR_O_C] & drg_q[HTR_O_D])
            ^ (drg_q[HTR_O_E] | drg_q[HTR_O_F]) ^ drg_q[HTR_O_G];
    fb = drg_q[HTR_T_A] ^ drg_q[HTR_T_B] ^ (drg_q[HTR_T_C] & drg_q[HTR_T_D])
       ^ (drg_q[HTR_T_E] & ~drg_q[HTR_T_F]) ^ drg_q[HTR_T_G] ^ cmp_bit;
    if (raw_valid)
    begin
      // Fold ratio raw bits into one compressed bit
      if (cmp_cnt_q + 3'h1 >= ratio_q)
      begin
        cmp_valid = 1'b1;
        cmp_cnt_d = '0;
        cmp_acc_d = 1'b0;
      end
      else
      begin
        cmp_cnt_d = cmp_cnt_q + 3'h1;
        cmp_acc_d = cmp_bit;
      end
    end
    if (cmp_valid)
    begin
      drg_d = {drg_q[HTR_STATE_W-2:0], fb} ^ {drg_q[0], {(HTR_STATE_W-1){1'b0}}};
      if (seed_q != HTR_SEED_BITS)
      begin
        seed_d = seed_q + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmp_cnt_q <= '0;
      cmp_acc_q <= 1'b0;
      drg_q <= '0;
      seed_q <= '0;
    end
    else
    begin
      cmp_cnt_q <= cmp_cnt_d;
      cmp_acc_q <= cmp_acc_d;
      drg_q <= drg_d;
      seed_q <= seed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly, hold-back and output gating

  htr_state_t st_q, st_d;
  logic [15:0] acc_q, acc_d;
  logic [4:0] nbit_q, nbit_d;
  logic [15:0] pend_q, pend_d;
  logic pend_v_q, pend_v_d;
  logic [5:0] hold_q, hold_d;
  logic [15:0] word_q, word_d;
  logic valid_q, valid_d;
  logic [4:0] width;
  logic seeded;
  logic bad;

  always_comb
  begin
    st_d = st_q;
    acc_d = acc_q;
    nbit_d = nbit_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    hold_d = hold_q;
    word_d = word_q;
    valid_d = 1'b0;
    width = word16_sel ? HTR_W16 : HTR_W8;
    seeded = (seed_q == HTR_SEED_BITS);
    bad = tfail_d || defect_d;
    case (st_q)
      HTR_ST_START:
      begin
        if (bad)
        begin
          st_d = HTR_ST_FAIL;
        end
        else if (seeded && win_ok_q && up_cnt_q == 10'(STARTUP_BITS))
        begin
          st_d = HTR_ST_RUN;
          nbit_d = '0;
        end
      end
      HTR_ST_RUN:
      begin
        if (bad)
        begin
          st_d = HTR_ST_FAIL;
          pend_v_d = 1'b0;
        end
        else
        begin
          if (cmp_valid)
          begin
            // One output bit per absorbed bit bounds the rate
            acc_d = {acc_q[14:0], out_bit};
            nbit_d = nbit_q + 5'h01;
            if (nbit_q + 5'h01 >= width)
            begin
              nbit_d = '0;
              // Held word keeps its place; newer is dropped so output never starves
              if (!pend_v_q)
              begin
                pend_d = word16_sel ? {acc_q[14:0], out_bit} : {8'h00, acc_q[6:0], out_bit};
                pend_v_d = 1'b1;
                hold_d = '0;
              end
            end
          end
          // Failure runs under the limit may sit inside a word, so hold it
          if (pend_v_q && raw_valid)
          begin
            hold_d = hold_q + 6'h01;
            if (hold_q + 6'h01 >= 6'(RUN_LIMIT))
            begin
              word_d = pend_q;
              valid_d = 1'b1;
              pend_v_d = 1'b0;
            end
          end
        end
      end
      HTR_ST_FAIL:
      begin
        pend_v_d = 1'b0;
      end
      default:
      begin
        st_d = HTR_ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= HTR_ST_START;
      acc_q <= '0;
      nbit_q <= '0;
      pend_q <= '0;
      pend_v_q <= 1'b0;
      hold_q <= '0;
      word_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      acc_q <= acc_d;
      nbit_q <= nbit_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      hold_q <= hold_d;
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  htr_status_t status_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q <= '{total_fail: tfail_q, defect: defect_q, seeded: seeded,
                    running: (st_q == HTR_ST_RUN)};
    end
  end

  assign rnd_word = word_q;
  assign rnd_valid = valid_q;
  assign status = status_q;

endmodule : htr_generator

`default_nettype wire

// ---- htr_pkg.sv ----
// Purpose: shared constants and types of the hybrid random generator
// Assumes: one raw entropy bit per qualified clock at most
// Notes: test thresholds are plain defaults, tune per source
package htr_pkg;

  // Total-failure and start-up figures
  localparam int HTR_RUN_LIMIT = 32;
  localparam int HTR_STARTUP_BITS = 512;

  // Online test window and acceptance band
  localparam int HTR_WIN_BITS = 256;
  localparam int HTR_WIN_W = 9;
  localparam logic [8:0] HTR_WIN_LAST = 9'h0FF;
  localparam logic [8:0] HTR_ONES_LO = 9'h060;
  localparam logic [8:0] HTR_ONES_HI = 9'h0A0;
  localparam logic [8:0] HTR_ONES_MID = 9'h080;

  // Entropy estimator: bias bounds and compression ratio range
  localparam logic [8:0] HTR_BIAS_UP = 9'h010;
  localparam logic [8:0] HTR_BIAS_DN = 9'h008;
  localparam logic [2:0] HTR_RATIO_MIN = 3'h2;
  localparam logic [2:0] HTR_RATIO_MAX = 3'h6;

  // Deterministic stage
  localparam int HTR_STATE_W = 351;
  localparam logic [9:0] HTR_SEED_BITS = 10'h15F;
  localparam int HTR_T_A = 350;
  localparam int HTR_T_B = 244;
  localparam int HTR_T_C = 100;
  localparam int HTR_T_D = 37;
  localparam int HTR_T_E = 12;
  localparam int HTR_T_F = 191;
  localparam int HTR_T_G = 303;
  localparam int HTR_O_A = 300;
  localparam int HTR_O_B = 171;
  localparam int HTR_O_C = 83;
  localparam int HTR_O_D = 290;
  localparam int HTR_O_E = 5;
  localparam int HTR_O_F = 222;
  localparam int HTR_O_G = 139;

  // Word formats
  localparam logic [4:0] HTR_W8 = 5'h08;
  localparam logic [4:0] HTR_W16 = 5'h10;

  typedef enum logic [1:0] {HTR_ST_START, HTR_ST_RUN, HTR_ST_FAIL} htr_state_t;

  typedef struct packed {
    logic total_fail;
    logic defect;
    logic seeded;
    logic running;
  } htr_status_t;

endpackage : htr_pkg

// ---- htr_generator_asserts.sv ----
// Purpose: port assertions of htr_generator
// Assumes: word16_sel changes only in reset
// Notes: status lags a cycle, so release checks are loose by one edge
`timescale 1ns/1ps
`default_nettype none
module htr_generator_asserts
  import htr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic raw_bit,
  input wire logic raw_valid,
  input wire logic word16_sel,
  input wire logic [15:0] rnd_word,
  input wire logic rnd_valid,
  input wire htr_status_t status
);
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence blocked_s;
    status.total_fail || status.defect;
  endsequence
  sequence silent_s;
    !rnd_valid [*2];
  endsequence
  ////////////////////////////////////////
  fail_sticky_a: assert property (status.total_fail |=> status.total_fail)
    else $error("fail flag dropped");
  defect_sticky_a: assert property (status.defect |=> status.defect)
    else $error("defect flag dropped");
  blocked_quiet_a: assert property (blocked_s |=> silent_s)
    else $error("word after failure");
  pulse_single_a: assert property (rnd_valid |=> !rnd_valid)
    else $error("words faster than input");
  word_hold_a: assert property (!rnd_valid |-> $stable(rnd_word))
    else $error("word changed without valid");
  byte_mode_a: assert property (rnd_valid && !word16_sel |-> rnd_word[15:8] == 8'h00)
    else $error("upper byte set in 8-bit mode");
  seed_first_a: assert property (rnd_valid |-> status.seeded && status.running)
    else $error("word before seeding");
  raw_paced_a: assert property (rnd_valid |-> $past(raw_valid))
    else $error("word without raw bit");
  run_seed_a: assert property (status.running |-> status.seeded)
    else $error("running while unseeded");
endmodule : htr_generator_asserts

bind htr_generator htr_generator_asserts u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .raw_bit(raw_bit), .raw_valid(raw_valid), .word16_sel(word16_sel),
  .rnd_word(rnd_word), .rnd_valid(rnd_valid), .status(status));
`default_nettype wire

// ---- tb_htr_generator.sv ----
// Purpose: self-checking bench of htr_generator
// Assumes: word16_sel is set only while in reset
// Notes: word values are not predicted, only release rules and counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_htr_generator
  import htr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn;
  logic raw_bit = 1'b0;
  logic raw_valid = 1'b0;
  logic word16_sel = 1'b0;
  logic [15:0] rnd_word;
  logic rnd_valid;
  htr_status_t status;
  logic [31:0] rng = 32'h0000276F;
  int error_cnt = 0;
  int cmp_count = 0;
  int raw_cnt = 0;
  int word_cnt = 0;
  int w;
  int min_raw;

  htr_generator dut (.sys_clk(sys_clk), .resetn(resetn), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .word16_sel(word16_sel), .rnd_word(rnd_word),
    .rnd_valid(rnd_valid), .status(status));

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // Model: count raw bits taken and words seen
  always @(posedge sys_clk)
  begin
    if (resetn === 1'b1 && rnd_valid === 1'b1)
    begin
      word_cnt++;
      // Seed plus first word at the lowest ratio, then the hold-back
      min_raw = (HTR_STATE_W + (word16_sel ? 16 : 8)) * int'(HTR_RATIO_MIN) + HTR_RUN_LIMIT;
      `CHK("start_bits", raw_cnt >= min_raw, 1'b1)
      `CHK("rate", word_cnt * (word16_sel ? 32 : 16) <= raw_cnt, 1'b1)
      `CHK("width", word16_sel | (rnd_word[15:8] == 8'h00), 1'b1)
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Mode 0 random with gaps, 1 stuck low, 2 biased 1-in-4
  task automatic feed(input int n, input int mode);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      #10;
      rng = xs(rng);
      raw_valid = rng[1] | rng[2] | (mode != 0);
      raw_bit = (mode == 0) ? rng[0] : (mode == 2 && i % 4 == 3);
      raw_cnt += raw_valid;
    end
    @(posedge sys_clk);
    #10;
    raw_valid = 1'b0;
  endtask : feed

  task automatic do_reset(input logic sel);
    @(posedge sys_clk);
    #10;
    resetn = 1'b0;
    word16_sel = sel;
    repeat (4) @(posedge sys_clk);
    #10;
    `CHK("reset", status, 4'h0)
    resetn = 1'b1;
    raw_cnt = 0;
    word_cnt = 0;
  endtask : do_reset

  task automatic wait_run();
    for (int k = 0; k < 80 && status.running !== 1'b1; k++)
      feed(100, 0);
    `CHK("running", status.running, 1'b1)
    `CHK("seeded", status.seeded, 1'b1)
    if (status.running !== 1'b1)
      final_report();
  endtask : wait_run
  ////////////////////////////////////////
  initial
  begin
    // A real falling edge, so the design's registers leave the unknown state
    #1 resetn = 1'b0;
    do_reset(1'b0);
    wait_run();
    feed(3000, 0);
    `CHK("words8", word_cnt > 0, 1'b1)
    `CHK("no_fail", status.total_fail, 1'b0)
    feed(40, 1);
    w = word_cnt;
    feed(600, 0);
    `CHK("run_fail", status.total_fail, 1'b1)
    `CHK("after_fail", word_cnt, w)
    do_reset(1'b1);
    wait_run();
    feed(3000, 0);
    `CHK("words16", word_cnt > 0, 1'b1)
    feed(600, 2);
    w = word_cnt;
    feed(600, 0);
    `CHK("run_defect", status.defect, 1'b1)
    `CHK("after_defect", word_cnt, w)
    do_reset(1'b0);
    feed(40, 1);
    feed(3000, 0);
    `CHK("start_fail", status.total_fail, 1'b1)
    `CHK("start_fail_words", word_cnt, 0)
    do_reset(1'b0);
    feed(2500, 2);
    `CHK("start_defect", status.defect, 1'b1)
    `CHK("start_defect_run", status.running, 1'b0)
    `CHK("start_defect_words", word_cnt, 0)
    final_report();
  end
endmodule : tb_htr_generator
`undef CHK
`default_nettype wire
